/* src/smbus_two_wire_interface.v */
// byte-oriented two-wire bus interface, master and slave
// assumes timer overflow pulses and host controls come from SYS_CLK_IN logic;
// SCL and SDA arrive from pins and are synchronised here
`include "smb_defs.vh"
`timescale 1ns/10ps
module smbus_two_wire_interface #(
   parameter [31:0] LOW_TIMEOUT_CYCLES = `LOW_TIMEOUT_CYCLES,
   parameter        FIFO_DEPTH         = `FIFO_DEPTH,
   parameter        FIFO_AW            = `FIFO_AW
) (
   // clock and reset
   input  wire       SYS_CLK_IN,
   input  wire       ARST_N_IN,
   // configuration
   input  wire       ENABLE_IN,
   input  wire       SLAVE_INHIBIT_IN,
   input  wire       LOW_TIMEOUT_EN_IN,
   input  wire       FREE_TIMEOUT_EN_IN,
   input  wire [1:0] CLK_SRC_SEL_IN,
   input  wire [3:0] TIMER_OVF_IN,
   input  wire [6:0] OWN_ADDR_IN,
   // control
   input  wire       START_REQ_IN,
   input  wire       STOP_REQ_IN,
   input  wire       ACK_VALID_IN,
   input  wire       ACK_VALUE_IN,
   // outgoing bytes
   input  wire [7:0] TX_DATA_IN,
   input  wire       TX_VALID_IN,
   output wire       TX_READY_OUT,
   // received bytes and events
   output wire [7:0] RX_DATA_OUT,
   output wire       RX_WAIT_OUT,
   output wire       BYTE_DONE_OUT,
   output wire       ACK_RCVD_OUT,
   output wire       ADDR_MATCH_OUT,
   output wire       ARB_LOST_OUT,
   output wire       STOP_SEEN_OUT,
   output wire       LOW_TIMEOUT_OUT,
   // status
   output wire       BUSY_OUT,
   output wire       MASTER_OUT,
   output wire       TX_MODE_OUT,
   // bus pins
   input  wire       SCL_IN,
   output wire       SCL_OUT,
   output wire       SCL_OE_OUT,
   input  wire       SDA_IN,
   output wire       SDA_OUT,
   output wire       SDA_OE_OUT
);

   localparam [2:0] ST_IDLE     = 3'h0;
   localparam [2:0] ST_MSTART   = 3'h1;
   localparam [2:0] ST_XFER     = 3'h2;
   localparam [2:0] ST_MSTOP    = 3'h3;
   localparam [2:0] ST_WAITSTOP = 3'h4;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg  [2:0] state_q;
   reg        scl_m_q;
   reg        scl_s_q;
   reg        scl_p_q;
   reg        sda_m_q;
   reg        sda_s_q;
   reg        sda_p_q;
   reg  [7:0] shift_q;
   reg  [3:0] bit_q;
   reg  [3:0] fcnt_q;
   reg  [1:0] tcnt_q;
   reg        step_q;
   reg        gen_high_q;
   reg        master_q;
   reg        tx_q;
   reg        rw_q;
   reg        addr_q;
   reg        ack_q;
   reg        hold_q;
   reg        inh_q;
   reg        busy_q;
   reg        start_pend_q;
   reg        stop_pend_q;
   reg        pop_q;
   reg        scl_oe_q;
   reg        sda_oe_q;
   reg        lo_q;
   reg  [7:0] rx_data_q;
   reg        rx_wait_q;
   reg        byte_done_q;
   reg        addr_match_q;
   reg        arb_lost_q;
   reg        stop_seen_q;
   reg        low_to_q;
   wire       tick;
   wire       start_det;
   wire       stop_det;
   wire       scl_rise;
   wire       scl_fall;
   wire       free_hit;
   wire       bus_end;
   wire       next_tx;
   wire       ovf_low;
   wire       fifo_valid;
   wire [7:0] fifo_data;
   wire       can_load;

   // ----------------------------------------------------------------------
   // outgoing byte buffer
   // ----------------------------------------------------------------------
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_tx_fifo (
      .clk_in        (SYS_CLK_IN),
      .rst_n_in      (ARST_N_IN),
      .in_valid_in   (TX_VALID_IN),
      .in_data_in    (TX_DATA_IN),
      .in_ready_out  (TX_READY_OUT),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_data),
      .out_ready_in  (pop_q)
   );

   // ----------------------------------------------------------------------
   // scl low timeout
   // ----------------------------------------------------------------------
   low_timeout_timer #(
      .CYCLES (LOW_TIMEOUT_CYCLES)
   ) u_low_timer (
      .clk_in       (SYS_CLK_IN),
      .rst_n_in     (ARST_N_IN),
      .enable_in    (LOW_TIMEOUT_EN_IN & ENABLE_IN),
      .scl_low_in   (~scl_s_q),
      .overflow_out (ovf_low)
   );

   // ----------------------------------------------------------------------
   // pin synchronisers and bus condition detection
   // ----------------------------------------------------------------------
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= SCL_IN;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= SDA_IN;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   assign tick      = TIMER_OVF_IN[CLK_SRC_SEL_IN];
   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   assign scl_rise  = scl_s_q & ~scl_p_q;
   assign scl_fall  = ~scl_s_q & scl_p_q;
   assign free_hit  = FREE_TIMEOUT_EN_IN & busy_q & scl_s_q & sda_s_q & tick
                      & (fcnt_q == `FREE_TIMEOUT_TICKS);
   assign bus_end   = stop_det | free_hit;
   assign next_tx   = master_q ^ rw_q;
   assign can_load  = fifo_valid & ~pop_q;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task go_idle;
      begin
         state_q   <= ST_IDLE;
         master_q  <= 1'b0;
         tx_q      <= 1'b0;
         hold_q    <= 1'b0;
         rx_wait_q <= 1'b0;
         addr_q    <= 1'b0;
         bit_q     <= 4'h0;
         scl_oe_q  <= 1'b0;
         sda_oe_q  <= 1'b0;
      end
   endtask

   task load_byte;
      begin
         shift_q  <= fifo_data;
         pop_q    <= 1'b1;
         sda_oe_q <= ~fifo_data[7];
         hold_q   <= 1'b0;
      end
   endtask

   task enter_stop;
      begin
         state_q     <= ST_MSTOP;
         step_q      <= 1'b0;
         sda_oe_q    <= 1'b1;
         scl_oe_q    <= 1'b1;
         hold_q      <= 1'b0;
         stop_pend_q <= STOP_REQ_IN;
      end
   endtask

   // ----------------------------------------------------------------------
   // bus engine
   // ----------------------------------------------------------------------
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_q      <= ST_IDLE;
         shift_q      <= 8'h00;
         bit_q        <= 4'h0;
         fcnt_q       <= 4'h0;
         tcnt_q       <= 2'h0;
         step_q       <= 1'b0;
         gen_high_q   <= 1'b0;
         master_q     <= 1'b0;
         tx_q         <= 1'b0;
         rw_q         <= 1'b0;
         addr_q       <= 1'b0;
         ack_q        <= 1'b0;
         hold_q       <= 1'b0;
         inh_q        <= 1'b0;
         busy_q       <= 1'b0;
         start_pend_q <= 1'b0;
         stop_pend_q  <= 1'b0;
         pop_q        <= 1'b0;
         scl_oe_q     <= 1'b0;
         sda_oe_q     <= 1'b0;
         lo_q         <= 1'b0;
         rx_data_q    <= 8'h00;
         rx_wait_q    <= 1'b0;
         byte_done_q  <= 1'b0;
         addr_match_q <= 1'b0;
         arb_lost_q   <= 1'b0;
         stop_seen_q  <= 1'b0;
         low_to_q     <= 1'b0;
      end else begin
         lo_q         <= 1'b0;
         pop_q        <= 1'b0;
         byte_done_q  <= 1'b0;
         addr_match_q <= 1'b0;
         arb_lost_q   <= 1'b0;
         stop_seen_q  <= bus_end;
         low_to_q     <= ovf_low;
         if (START_REQ_IN) begin
            start_pend_q <= 1'b1;
         end
         if (STOP_REQ_IN) begin
            stop_pend_q <= 1'b1;
         end
         if (start_det) begin
            busy_q <= 1'b1;
            inh_q  <= SLAVE_INHIBIT_IN;
         end else if (bus_end) begin
            busy_q <= 1'b0;
         end
         if (!(scl_s_q & sda_s_q) || !busy_q) begin
            fcnt_q <= 4'h0;
         end else if (tick && fcnt_q != `FREE_TIMEOUT_TICKS) begin
            fcnt_q <= fcnt_q + 4'h1;
         end
         if (!ENABLE_IN || ovf_low) begin
            go_idle;
            start_pend_q <= 1'b0;
            stop_pend_q  <= 1'b0;
         end else if (start_det && state_q != ST_MSTART && state_q != ST_MSTOP) begin
            go_idle;
            state_q <= ST_XFER;
            addr_q  <= 1'b1;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (start_pend_q && !busy_q && can_load) begin
                     state_q      <= ST_MSTART;
                     step_q       <= 1'b0;
                     start_pend_q <= START_REQ_IN;
                     sda_oe_q     <= 1'b1;
                  end
               end
               ST_MSTART: begin
                  if (tick) begin
                     if (!step_q) begin
                        scl_oe_q <= 1'b1;
                        step_q   <= 1'b1;
                     end else begin
                        load_byte;
                        rw_q       <= fifo_data[`DIR_BIT];
                        master_q   <= 1'b1;
                        tx_q       <= 1'b1;
                        addr_q     <= 1'b1;
                        ack_q      <= 1'b1;
                        bit_q      <= 4'h0;
                        gen_high_q <= 1'b0;
                        state_q    <= ST_XFER;
                     end
                  end
               end
               ST_XFER: begin
                  if (bus_end) begin
                     go_idle;
                  end else begin
                     // master clock: one tick low, two ticks high after release
                     if (master_q) begin
                        if (!gen_high_q) begin
                           if (tick && !hold_q && !scl_s_q && !scl_p_q) begin
                              scl_oe_q   <= 1'b0;
                              gen_high_q <= 1'b1;
                              tcnt_q     <= 2'h0;
                           end
                        end else if (scl_s_q && tick) begin
                           tcnt_q <= tcnt_q + 2'h1;
                           if (tcnt_q == `HIGH_LAST_TICK) begin
                              scl_oe_q   <= 1'b1;
                              gen_high_q <= 1'b0;
                           end
                        end
                     end else begin
                        scl_oe_q <= hold_q;
                     end
                     // host answers while scl is held low
                     if (hold_q) begin
                        if (rx_wait_q) begin
                           if (ACK_VALID_IN) begin
                              sda_oe_q  <= ACK_VALUE_IN;
                              rx_wait_q <= 1'b0;
                              hold_q    <= 1'b0;
                           end
                        end else if (master_q && stop_pend_q) begin
                           enter_stop;
                        end else if (tx_q && ack_q && can_load) begin
                           load_byte;
                        end
                     end
                     // bit sampling on the rising edge
                     if (scl_rise) begin
                        if (bit_q != `ACK_BIT) begin
                           shift_q <= {shift_q[6:0], sda_s_q};
                           if (tx_q && master_q && shift_q[7] && !sda_s_q) begin
                              master_q   <= 1'b0;
                              tx_q       <= 1'b0;
                              arb_lost_q <= 1'b1;
                              scl_oe_q   <= 1'b0;
                           end
                        end else if (tx_q) begin
                           ack_q <= ~sda_s_q;
                        end
                     end
                     // data changes on the falling edge
                     if (scl_fall) begin
                        if (bit_q < `LAST_DATA_BIT) begin
                           bit_q    <= bit_q + 4'h1;
                           sda_oe_q <= tx_q & ~shift_q[7];
                        end else if (bit_q == `LAST_DATA_BIT) begin
                           bit_q    <= `ACK_BIT;
                           sda_oe_q <= 1'b0;
                           if (addr_q && !master_q) begin
                              if (shift_q[7:1] == OWN_ADDR_IN && !inh_q) begin
                                 sda_oe_q     <= 1'b1;
                                 rw_q         <= shift_q[`DIR_BIT];
                                 ack_q        <= 1'b1;
                                 addr_match_q <= 1'b1;
                              end else begin
                                 state_q <= ST_WAITSTOP;
                              end
                           end else if (!tx_q) begin
                              hold_q    <= 1'b1;
                              rx_wait_q <= 1'b1;
                              rx_data_q <= shift_q;
                           end
                        end else begin
                           bit_q       <= 4'h0;
                           addr_q      <= 1'b0;
                           sda_oe_q    <= 1'b0;
                           byte_done_q <= 1'b1;
                           tx_q        <= next_tx;
                           if (master_q && stop_pend_q) begin
                              enter_stop;
                           end else if (tx_q && !ack_q && !master_q) begin
                              state_q <= ST_WAITSTOP;
                           end else if (tx_q && !ack_q) begin
                              hold_q <= 1'b1;
                           end else if (next_tx) begin
                              if (can_load) begin
                                 load_byte;
                              end else begin
                                 hold_q <= 1'b1;
                              end
                           end
                        end
                     end
                  end
               end
               ST_MSTOP: begin
                  if (!step_q) begin
                     if (tick) begin
                        scl_oe_q <= 1'b0;
                        step_q   <= 1'b1;
                     end
                  end else if (scl_s_q && tick) begin
                     sda_oe_q <= 1'b0;
                     master_q <= 1'b0;
                     tx_q     <= 1'b0;
                     state_q  <= ST_WAITSTOP;
                  end
               end
               ST_WAITSTOP: begin
                  scl_oe_q <= 1'b0;
                  sda_oe_q <= 1'b0;
                  hold_q   <= 1'b0;
                  if (bus_end) begin
                     go_idle;
                  end
               end
               default: begin
                  go_idle;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign SCL_OUT         = lo_q;
   assign SDA_OUT         = lo_q;
   assign SCL_OE_OUT      = scl_oe_q;
   assign SDA_OE_OUT      = sda_oe_q;
   assign RX_DATA_OUT     = rx_data_q;
   assign RX_WAIT_OUT     = rx_wait_q;
   assign BYTE_DONE_OUT   = byte_done_q;
   assign ACK_RCVD_OUT    = ack_q;
   assign ADDR_MATCH_OUT  = addr_match_q;
   assign ARB_LOST_OUT    = arb_lost_q;
   assign STOP_SEEN_OUT   = stop_seen_q;
   assign LOW_TIMEOUT_OUT = low_to_q;
   assign BUSY_OUT        = busy_q;
   assign MASTER_OUT      = master_q;
   assign TX_MODE_OUT     = tx_q;

endmodule

/* src/smb_defs.vh */
// constants for the two-wire serial bus interface
// assumes a 100 MHz system clock and timer overflow pulses on the same clock
// Summary of operation
// - host moves whole bytes; the hardware shifts every bit on the bus itself.
// - bit rate up to one twentieth of the system clock, as master or slave.
// - works as master, slave or both on a bus with several masters.
// - whoever sends start plus address is master and makes every clock pulse.
// - start, address byte (address in bits 7-1, direction bit 0), data, stop.
// - direction bit 1 means read with slave sending; 0 means write.
// - receiver acks each byte with SDA low while SCL high; high is nack.
// - transmitter sends one byte then awaits the receiver's ack, both directions.
// - master ends the transfer with a stop that frees the bus.
// - master starts only on a free bus: after stop or free timeout.
// - master that releases SDA but reads low loses and turns slave.
// - winning master carries on without break or retransmission.
// - slave may hold SCL low; master waits for real release before high.
// - an SCL low period longer than 25 ms is a timeout.
// - after a low timeout the bus communication is reset within 10 ms.
// - timeout timer reloads while SCL high and counts while low, when enabled.
// - SCL and SDA are only pulled low or released, never driven high.
// - one shift register serves sent and received bytes and addresses.
// - with free timeout on, both lines high over 10 ticks acts as stop.
// - clock source select picks one of four timer overflows for timing.
// - one event per byte: after ack when sending, before ack when receiving; BYTE_DONE_OUT pulses after ack either way, RX_WAIT_OUT before ack on receive.
`ifndef SMB_DEFS_VH
`define SMB_DEFS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ        100000000
`define LOW_TIMEOUT_US     25000
`define LOW_TIMEOUT_CYCLES (`LOW_TIMEOUT_US * (`CLK_FREQ_HZ / 1000000))
`define FREE_TIMEOUT_TICKS 4'ha
`define HIGH_LAST_TICK     2'h1

// ----------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------
`define LAST_DATA_BIT      4'h7
`define ACK_BIT            4'h8
`define DIR_BIT            0
`define FIFO_DEPTH         8
`define FIFO_AW            3

`endif

/* src/byte_fifo.v */
// small synchronous fifo with valid and ready on both sides
// assumes depth is a power of two and one clock for both sides
`timescale 1ns/10ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             clk_in,
   input  wire             rst_n_in,
   // filling side
   input  wire             in_valid_in,
   input  wire [WIDTH-1:0] in_data_in,
   output reg              in_ready_out,
   // draining side
   output wire             out_valid_out,
   output wire [WIDTH-1:0] out_data_out,
   input  wire             out_ready_in
);

   localparam [AW:0] FULL = DEPTH[AW:0];

   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [AW-1:0]    wr_q;
   reg  [AW-1:0]    rd_q;
   reg  [AW:0]      cnt_q;
   wire             wr_en;
   wire             rd_en;
   wire [AW:0]      cnt_d;

   assign wr_en         = in_valid_in & in_ready_out;
   assign rd_en         = out_ready_in & out_valid_out;
   assign cnt_d         = cnt_q + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
   assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign out_data_out  = mem_q[rd_q];

   always @(posedge clk_in) begin
      if (wr_en) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q         <= {AW{1'b0}};
         rd_q         <= {AW{1'b0}};
         cnt_q        <= {(AW+1){1'b0}};
         in_ready_out <= 1'b1;
      end else begin
         if (wr_en) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (rd_en) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         cnt_q        <= cnt_d;
         in_ready_out <= (cnt_d != FULL);
      end
   end

endmodule

/* src/low_timeout_timer.v */
// counter that flags an over-long SCL low period
// assumes scl_low_in is already synchronised to clk_in
`include "smb_defs.vh"
`timescale 1ns/10ps
module low_timeout_timer #(
   parameter [31:0] CYCLES = `LOW_TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire clk_in,
   input  wire rst_n_in,
   // control
   input  wire enable_in,
   input  wire scl_low_in,
   // result
   output reg  overflow_out
);

   reg [31:0] cnt_q;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q        <= 32'h0;
         overflow_out <= 1'b0;
      end else if (!enable_in || !scl_low_in) begin
         cnt_q        <= 32'h0;
         overflow_out <= 1'b0;
      end else if (cnt_q == CYCLES - 32'h1) begin
         cnt_q        <= 32'h0;
         overflow_out <= 1'b1;
      end else begin
         cnt_q        <= cnt_q + 32'h1;
         overflow_out <= 1'b0;
      end
   end

endmodule

/* sim/smb_slave_model.sv */
// behavioural slave at the far end of the two-wire bus
// assumes the bench resolves both lines open-drain with pull-ups
`timescale 1ns/10ps
module smb_slave_model #(
   parameter [6:0] ADDR = 7'h2a,
   parameter [7:0] RDB  = 8'hc5
) (
   input  wire       scl,
   input  wire       sda,
   input  wire       str_in,
   output reg        sda_oe = 1'b0,
   output reg        scl_oe = 1'b0,
   output reg  [7:0] last = 8'h00
);
   integer   n = 0;
   reg       sel = 1'b0, rd = 1'b0, fst = 1'b0;
   reg [7:0] sh = 8'h00;
   always @(negedge sda) if (scl) begin
      n = 0;
      fst = 1'b1;
      sel = 1'b0;
   end
   always @(posedge sda) if (scl) sel = 1'b0;
   always @(posedge scl) if (n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 1;
   end else if (rd && sda) sel = 1'b0;
   always @(negedge scl) begin
      #20;
      if (n == 8) begin
         if (fst) sel = (sh[7:1] == ADDR);
         if (fst) rd = sh[0];
         sda_oe = sel && (fst || !rd);
         if (sel && !fst && !rd) last = sh;
         fst = 1'b0;
         n = 9;
      end else begin
         if (n == 9 && str_in && sel) scl_oe = 1'b1;
         if (n == 9) n = 0;
         sda_oe = sel && rd && !RDB[7-n];
         if (scl_oe) #400 scl_oe = 1'b0;
      end
   end
endmodule

/* sim/smb_monitor.sv */
// assertions on the ports of the two-wire interface
// assumes binding to the top module, scl_in already resolved
`timescale 1ns/10ps
module smb_monitor #(parameter [31:0] LOW_TIMEOUT_CYCLES = 32'd200) (
   input wire SYS_CLK_IN, ARST_N_IN, ENABLE_IN, LOW_TIMEOUT_EN_IN, ACK_VALID_IN, SCL_IN,
   input wire BYTE_DONE_OUT, RX_WAIT_OUT, STOP_SEEN_OUT, LOW_TIMEOUT_OUT, BUSY_OUT,
   input wire SCL_OUT, SCL_OE_OUT, SDA_OUT, SDA_OE_OUT
);
   logic [31:0] low_q;
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN) low_q <= 32'h0;
      else low_q <= (SCL_IN || !LOW_TIMEOUT_EN_IN) ? 32'h0 : low_q + 32'h1;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   scl_od_a: assert property (SCL_OUT == 1'b0)
      else $error("scl driven high");
   sda_od_a: assert property (SDA_OUT == 1'b0)
      else $error("sda driven high");
   disable_release_a: assert property (!ENABLE_IN [*3] |-> !SCL_OE_OUT && !SDA_OE_OUT)
      else $error("lines held while disabled");
   low_count_a: assert property (LOW_TIMEOUT_OUT |-> LOW_TIMEOUT_EN_IN &&
      low_q >= LOW_TIMEOUT_CYCLES - 1 && low_q <= LOW_TIMEOUT_CYCLES + 8) else $error("bad timeout");
   timeout_reset_a: assert property (LOW_TIMEOUT_OUT |=> !SCL_OE_OUT && !SDA_OE_OUT)
      else $error("no reset after timeout");
   done_pulse_a: assert property (BYTE_DONE_OUT |=> !BYTE_DONE_OUT)
      else $error("byte done too long");
   rx_hold_a: assert property (RX_WAIT_OUT && !ACK_VALID_IN && ENABLE_IN |=> RX_WAIT_OUT)
      else $error("rx wait dropped");
   rx_stretch_a: assert property (RX_WAIT_OUT && $past(RX_WAIT_OUT) |-> SCL_OE_OUT)
      else $error("scl not held");
   stop_free_a: assert property (STOP_SEEN_OUT |-> ##[0:1] !BUSY_OUT)
      else $error("busy after stop");
   c_done: cover property (BYTE_DONE_OUT);
   c_rx: cover property (RX_WAIT_OUT);
   c_lto: cover property (LOW_TIMEOUT_OUT);
endmodule
bind smbus_two_wire_interface smb_monitor #(.LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES)) u_mon (
   .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .ENABLE_IN(ENABLE_IN),
   .LOW_TIMEOUT_EN_IN(LOW_TIMEOUT_EN_IN), .ACK_VALID_IN(ACK_VALID_IN), .SCL_IN(SCL_IN),
   .BYTE_DONE_OUT(BYTE_DONE_OUT), .RX_WAIT_OUT(RX_WAIT_OUT), .STOP_SEEN_OUT(STOP_SEEN_OUT),
   .LOW_TIMEOUT_OUT(LOW_TIMEOUT_OUT), .BUSY_OUT(BUSY_OUT), .SCL_OUT(SCL_OUT),
   .SCL_OE_OUT(SCL_OE_OUT), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT));

/* sim/tb.sv */
// self-checking bench: interface as master against one slave model
// assumes design, model and monitor compiled first
`timescale 1ns/10ps
module tb;
   typedef struct {logic [1:0] s; logic t; logic rw; logic [6:0] a; logic [7:0] d;} row_t;
   row_t rows [5] = '{'{0, 0, 0, 7'h2a, 8'h96}, '{1, 1, 0, 7'h2a, 8'h01},
      '{2, 0, 1, 7'h2a, 8'h00}, '{3, 1, 1, 7'h2a, 8'h00}, '{0, 0, 0, 7'h15, 8'h5a}};
   logic       clk = 0, rst_n = 0, en = 1, st = 0, sp = 0, akv = 0, txv = 0, hold = 0, str = 0;
   logic       lto_q = 0, lte = 1, akval = 0;
   logic [1:0] src = 0;
   logic [3:0] ovf = 0;
   logic [7:0] txd = 0;
   wire        rdy, rxw, bd, ak, lto, stop, busy, scl_oe, sda_oe, m_scl, m_sda, mst, txm;
   wire [7:0]  rxd, m_last;
   wire        scl = !(scl_oe | m_scl | hold);
   wire        sda = !(sda_oe | m_sda);
   int         n_errors = 0, num_checks = 0, tk = 0;
   smbus_two_wire_interface #(.LOW_TIMEOUT_CYCLES(32'd200)) u_smbus_two_wire_interface (
      .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .ENABLE_IN(en), .SLAVE_INHIBIT_IN(1'b0),
      .LOW_TIMEOUT_EN_IN(lte), .FREE_TIMEOUT_EN_IN(1'b1), .CLK_SRC_SEL_IN(src),
      .TIMER_OVF_IN(ovf), .OWN_ADDR_IN(7'h33), .START_REQ_IN(st), .STOP_REQ_IN(sp),
      .ACK_VALID_IN(akv), .ACK_VALUE_IN(akval), .TX_DATA_IN(txd), .TX_VALID_IN(txv),
      .TX_READY_OUT(rdy), .RX_DATA_OUT(rxd), .RX_WAIT_OUT(rxw), .BYTE_DONE_OUT(bd),
      .ACK_RCVD_OUT(ak), .ADDR_MATCH_OUT(), .ARB_LOST_OUT(), .STOP_SEEN_OUT(stop),
      .LOW_TIMEOUT_OUT(lto), .BUSY_OUT(busy), .MASTER_OUT(mst), .TX_MODE_OUT(txm), .SCL_IN(scl),
      .SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe));
   smb_slave_model u_smb_slave_model (.scl(scl), .sda(sda), .str_in(str), .sda_oe(m_sda),
      .scl_oe(m_scl), .last(m_last));
   initial forever #5 clk = !clk;
   always @(posedge clk) begin
      tk <= tk + 1;
      ovf <= (tk % 8 == 7) ? 4'h1 << src : 4'h0;
      if (lto) lto_q <= 1'b1;
   end
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task xfer(input row_t r);
      src <= r.s;
      str <= r.t;
      {txd, txv, st} <= {r.a, r.rw, 2'h3};
      @(posedge clk);
      {txd, txv, st} <= {r.d, !r.rw, 1'b0};
      @(posedge clk);
      txv <= 1'b0;
      @(posedge clk iff bd);
      chk("addr ack", ak, r.a == 7'h2a);
      chk("mode", {mst, txm}, {1'b1, !r.rw});
      if (r.rw) @(posedge clk iff rxw);
      if (r.rw) chk("read byte", rxd, 8'hc5);
      {sp, akv, akval} <= {1'b1, r.rw, r.t};
      @(posedge clk);
      {sp, akv} <= 2'h0;
      if (!r.rw && r.a == 7'h2a) @(posedge clk iff bd);
      if (!r.rw && r.a == 7'h2a) chk("written", m_last, r.d);
      @(posedge clk iff stop);
      @(posedge clk);
      chk("bus free", busy, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset", {rdy, scl_oe, sda_oe, busy}, 4'h8);
      repeat (3) @(posedge clk);
      foreach (rows[i]) xfer(rows[i]);
      hold <= 1'b1;
      lte <= 1'b0;
      repeat (250) @(posedge clk);
      chk("timeout off", lto_q, 1'b0);
      lte <= 1'b1;
      repeat (250) @(posedge clk);
      hold <= 1'b0;
      chk("low timeout", {lto_q, scl_oe, sda_oe}, 3'h4);
      txv <= 1'b1;
      repeat (9) @(posedge clk);
      txv <= 1'b0;
      en <= 1'b0;
      repeat (4) @(posedge clk);
      chk("full, idle", {rdy, scl_oe, sda_oe}, 3'h0);
      finish_test;
   end
   initial begin
      #300000;
      n_errors++;
      finish_test;
   end
endmodule
